/* File: core/rfm_regs.sv */
// Rail fault mask, force-on and output one power-good grouping registers
// Operation
// - Force-on clear: enable follows the pin only
// - Force-on set: on unless disable bit 0
// - First mask: bit7 linear2, bit6 converterA, bucks
// - Mask 1 blocks shutdown from that rail
// - Second mask: linear1, termination, B2, B1, linear3
// - Masks at A2h and A3h, variant defaults
// - Output one grouping register at A4h
// - Grouping bit 0 includes, 1 excludes rail
`timescale 1ns/1ps
`include "rfm_map.svh"
module rfm_regs #(
    parameter logic [7:0] DEF_FORCE_ON = `RFM_DEF_FORCE_ON,
    parameter logic [7:0] DEF_MASK_FIRST = `RFM_DEF_FAULT_MASK_FIRST,
    parameter logic [7:0] DEF_MASK_SECOND = `RFM_DEF_FAULT_MASK_SECOND,
    parameter logic [7:0] DEF_PG_GROUP = `RFM_DEF_PG_GROUP_FIRST
) (
    input wire logic clk,
    input wire logic resetn,
    input wire rfm_pkg::rfm_reg_req_t req,
    output logic [7:0] rdata,
    input wire logic linear_third_pin_en,
    input wire logic linear_third_disable_bit,
    output logic linear_third_enable,
    input wire rfm_pkg::rfm_group_first_t fault_first,
    input wire rfm_pkg::rfm_group_second_t fault_second,
    input wire rfm_pkg::rfm_group_first_t pg_first,
    output logic shutdown_req,
    output logic output_one_pg
);
    // Reserved second mask bits need their fixed default levels
    if (DEF_MASK_SECOND[`RFM_BIT_RSVD_ZERO] != 1'b0 || DEF_MASK_SECOND[7] != 1'b0
        || DEF_MASK_SECOND[`RFM_BIT_RSVD_ONE] != 1'b1) begin : g_bad_default
        $error("Second fault mask default breaks the reserved bit levels");
    end

    logic [7:0] force_on_ff;
    logic [7:0] fault_mask_first_ff;
    logic [7:0] fault_mask_second_ff;
    logic [7:0] pg_group_first_ff;
    logic [7:0] rdata_ff;
    logic shutdown_ff;
    logic pg_ff;
    logic en_ff;
    logic [7:0] fault_first_s1, fault_first_s2;
    logic [4:0] fault_second_s1, fault_second_s2;
    logic [7:0] pg_first_s1, pg_first_s2;
    logic pin_s1, pin_s2, dis_s1, dis_s2;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_first_s1 <= 8'h00;
            fault_first_s2 <= 8'h00;
            fault_second_s1 <= 5'h00;
            fault_second_s2 <= 5'h00;
            pg_first_s1 <= 8'h00;
            pg_first_s2 <= 8'h00;
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            dis_s1 <= 1'b0;
            dis_s2 <= 1'b0;
        end else begin
            fault_first_s1 <= fault_first;
            fault_first_s2 <= fault_first_s1;
            fault_second_s1 <= fault_second;
            fault_second_s2 <= fault_second_s1;
            pg_first_s1 <= pg_first;
            pg_first_s2 <= pg_first_s1;
            pin_s1 <= linear_third_pin_en;
            pin_s2 <= pin_s1;
            dis_s1 <= linear_third_disable_bit;
            dis_s2 <= dis_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            force_on_ff <= DEF_FORCE_ON;
            fault_mask_first_ff <= DEF_MASK_FIRST;
            fault_mask_second_ff <= DEF_MASK_SECOND;
            pg_group_first_ff <= DEF_PG_GROUP;
        end else if (req.wr) begin
            if (hit(req.addr, `RFM_OFS_FORCE_ON)) begin
                force_on_ff <= req.wdata;
            end
            if (hit(req.addr, `RFM_OFS_FAULT_MASK_FIRST)) begin
                fault_mask_first_ff <= req.wdata;
            end
            if (hit(req.addr, `RFM_OFS_FAULT_MASK_SECOND)) begin
                fault_mask_second_ff <= req.wdata & `RFM_MASK_SECOND_RW;
            end
            if (hit(req.addr, `RFM_OFS_PG_GROUP_FIRST)) begin
                pg_group_first_ff <= req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads, unmapped read zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 8'h00;
        end else if (req.rd) begin
            case (1'b1)
                hit(req.addr, `RFM_OFS_FORCE_ON): rdata_ff <= force_on_ff;
                hit(req.addr, `RFM_OFS_FAULT_MASK_FIRST): rdata_ff <= fault_mask_first_ff;
                hit(req.addr, `RFM_OFS_FAULT_MASK_SECOND): rdata_ff <= fault_mask_second_ff;
                hit(req.addr, `RFM_OFS_PG_GROUP_FIRST): rdata_ff <= pg_group_first_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end
    assign rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Rail control outputs
    logic nxt_shutdown, nxt_pg, nxt_en;
    always_comb begin
        nxt_shutdown = |(fault_first_s2 & ~fault_mask_first_ff)
            | |(fault_second_s2 & ~fault_mask_second_ff[4:0]);
        nxt_pg = &(pg_first_s2 | pg_group_first_ff);
        if (force_on_ff[`RFM_BIT_LINEAR_THIRD_FORCE_ON]) begin
            nxt_en = dis_s2;
        end else begin
            nxt_en = pin_s2;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shutdown_ff <= 1'b0;
            pg_ff <= 1'b0;
            en_ff <= 1'b0;
        end else begin
            shutdown_ff <= nxt_shutdown;
            pg_ff <= nxt_pg;
            en_ff <= nxt_en;
        end
    end
    assign shutdown_req = shutdown_ff;
    assign output_one_pg = pg_ff;
    assign linear_third_enable = en_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_mask_write;
        @(posedge clk) disable iff (!resetn)
        (req.wr && req.addr == `RFM_OFS_FAULT_MASK_FIRST) |=> fault_mask_first_ff == $past(req.wdata);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("First mask not written");
    property p_second_top;
        @(posedge clk) disable iff (!resetn) fault_mask_second_ff[7] == 1'b0;
    endproperty
    a_second_top: assert property (p_second_top) else $error("Second mask bit 7 set");
    property p_shutdown;
        @(posedge clk) disable iff (!resetn)
        (|(fault_first_s2 & ~fault_mask_first_ff)) |=> shutdown_req;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("Unmasked fault missed");
    property p_masked;
        @(posedge clk) disable iff (!resetn)
        (((fault_first_s2 & ~fault_mask_first_ff) == 8'h00)
            && ((fault_second_s2 & ~fault_mask_second_ff[4:0]) == 5'h00)) |=> !shutdown_req;
    endproperty
    a_masked: assert property (p_masked) else $error("Masked fault shut down");
    property p_pg;
        @(posedge clk) disable iff (!resetn)
        ((pg_first_s2 | pg_group_first_ff) != 8'hFF) |=> !output_one_pg;
    endproperty
    a_pg: assert property (p_pg) else $error("Good with included rail bad");
    property p_pg_excl;
        @(posedge clk) disable iff (!resetn) (pg_group_first_ff == 8'hFF) |=> output_one_pg;
    endproperty
    a_pg_excl: assert property (p_pg_excl) else $error("Excluded rails not ignored");
    property p_force;
        @(posedge clk) disable iff (!resetn)
        (force_on_ff[0] && dis_s2) |=> linear_third_enable;
    endproperty
    a_force: assert property (p_force) else $error("Force-on ignored");
    property p_pin;
        @(posedge clk) disable iff (!resetn)
        (!force_on_ff[0]) |=> linear_third_enable == $past(pin_s2);
    endproperty
    a_pin: assert property (p_pin) else $error("Pin control ignored");
    property p_read;
        @(posedge clk) disable iff (!resetn)
        (req.rd && req.addr == `RFM_OFS_PG_GROUP_FIRST && !req.wr) |=> rdata == pg_group_first_ff;
    endproperty
    a_read: assert property (p_read) else $error("Grouping read wrong");
    property p_fault_second;
        @(posedge clk) disable iff (!resetn)
        (|(fault_second_s2 & ~fault_mask_second_ff[4:0])) |=> shutdown_req;
    endproperty
    a_fault_second: assert property (p_fault_second) else $error("Unmasked second group fault missed");
    property p_force_off;
        @(posedge clk) disable iff (!resetn)
        (force_on_ff[0] && !dis_s2) |=> !linear_third_enable;
    endproperty
    a_force_off: assert property (p_force_off) else $error("Disable bit ignored under force-on");
    property p_second_write;
        @(posedge clk) disable iff (!resetn)
        (req.wr && req.addr == `RFM_OFS_FAULT_MASK_SECOND) |=> fault_mask_second_ff[4:0] == $past(req.wdata[4:0]);
    endproperty
    a_second_write: assert property (p_second_write) else $error("Second mask not written");
    property p_unmapped_read;
        @(posedge clk) disable iff (!resetn)
        (req.rd && (req.addr < `RFM_OFS_FORCE_ON || req.addr > `RFM_OFS_PG_GROUP_FIRST)) |=> rdata == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero");
    c_shutdown: cover property (@(posedge clk) disable iff (!resetn) $rose(shutdown_req));
    c_pg: cover property (@(posedge clk) disable iff (!resetn) $rose(output_one_pg));
    c_force: cover property (@(posedge clk) disable iff (!resetn) force_on_ff[0] && linear_third_enable);
    c_masked_fault: cover property (@(posedge clk) disable iff (!resetn)
        (|(fault_first_s2 & fault_mask_first_ff)) && !shutdown_req);
endmodule : rfm_regs

/* File: core/rfm_map.svh */
// Register offsets, field positions and default values of the rail fault mask bank
`ifndef RFM_MAP_SVH
`define RFM_MAP_SVH
`define RFM_OFS_FORCE_ON 8'hA1
`define RFM_OFS_FAULT_MASK_FIRST 8'hA2
`define RFM_OFS_FAULT_MASK_SECOND 8'hA3
`define RFM_OFS_PG_GROUP_FIRST 8'hA4
`define RFM_BIT_LINEAR_THIRD_FORCE_ON 0
`define RFM_BIT_RSVD_ZERO 6
`define RFM_BIT_RSVD_ONE 5
`define RFM_MASK_SECOND_RW 8'h7F
`define RFM_DEF_FORCE_ON 8'h00
`define RFM_DEF_FAULT_MASK_FIRST 8'h00
`define RFM_DEF_FAULT_MASK_SECOND 8'h20
`define RFM_DEF_PG_GROUP_FIRST 8'hFF
`endif

/* File: core/rfm_pkg.sv */
// Types of the rail fault mask bank
package rfm_pkg;
    // Rails of the first group, bit 7 down to 0
    typedef struct packed {
        logic linear_reg_second;
        logic converter_a_rail;
        logic [5:0] step_down_rail;
    } rfm_group_first_t;
    // Rails of the second group, bit 4 down to 0
    typedef struct packed {
        logic linear_reg_first;
        logic termination_reg;
        logic converter_b_second_rail;
        logic converter_b_first_rail;
        logic linear_reg_third;
    } rfm_group_second_t;
    // Register request port, reads and writes
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rfm_reg_req_t;
endpackage : rfm_pkg

/* File: verification/rfm_host_model.sv */
// Register host model driving the bank's request port
`timescale 1ns/1ps
module rfm_host_model (
    input wire logic clk,
    output rfm_pkg::rfm_reg_req_t req,
    input wire logic [7:0] rdata
);
    initial req = '0;
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'hA3) v[6:5] = 2'b01;
        @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk) req <= '0;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk) req <= '0;
        #1 q = rdata;
    endtask : read_reg
endmodule : rfm_host_model

/* File: verification/testbench.sv */
// Self-checking bench of the rail fault mask bank
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic resetn;
    rfm_pkg::rfm_reg_req_t req;
    logic [7:0] rdata;
    logic pin_en;
    logic dis_bit;
    logic lin3_en;
    rfm_pkg::rfm_group_first_t flt1;
    rfm_pkg::rfm_group_second_t flt2;
    rfm_pkg::rfm_group_first_t pg1;
    logic shut;
    logic pg_out;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] q;
    rfm_regs uut (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata), .linear_third_pin_en(pin_en),
        .linear_third_disable_bit(dis_bit), .linear_third_enable(lin3_en), .fault_first(flt1),
        .fault_second(flt2), .pg_first(pg1), .shutdown_req(shut), .output_one_pg(pg_out));
    rfm_host_model host (.clk(clk), .req(req), .rdata(rdata));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    task automatic give_verdict();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    task automatic test_defaults();
        logic [7:0] exp [5] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'hFF};
        for (int i = 0; i < 5; i++) begin
            host.read_reg(8'hA0 + i[7:0], q);
            check(q, exp[i]);
        end
    endtask : test_defaults
    task automatic test_shutdown();
        for (int i = 0; i < 13; i++) begin
            host.write_reg(8'hA2, 8'h00);
            host.write_reg(8'hA3, 8'h00);
            @(posedge clk) {flt2, flt1} <= 13'h0001 << i;
            settle();
            check({7'h00, shut}, 8'h01);
            if (i < 8) host.write_reg(8'hA2, 8'h01 << i);
            else host.write_reg(8'hA3, 8'h01 << (i - 8));
            settle();
            check({7'h00, shut}, 8'h00);
            @(posedge clk) {flt2, flt1} <= '0;
        end
        host.write_reg(8'hA3, 8'hFF);
        host.read_reg(8'hA3, q);
        check(q, 8'h3F);
    endtask : test_shutdown
    task automatic test_pg_group();
        for (int i = 0; i < 8; i++) begin
            host.write_reg(8'hA4, 8'h00);
            @(posedge clk) pg1 <= 8'hFF;
            settle();
            check({7'h00, pg_out}, 8'h01);
            @(posedge clk) pg1 <= ~(8'h01 << i);
            settle();
            check({7'h00, pg_out}, 8'h00);
            host.write_reg(8'hA4, 8'h01 << i);
            host.read_reg(8'hA4, q);
            check(q, 8'h01 << i);
            settle();
            check({7'h00, pg_out}, 8'h01);
        end
    endtask : test_pg_group
    task automatic test_force_on();
        for (int f = 0; f < 2; f++) begin
            host.write_reg(8'hA1, {7'h00, f[0]});
            host.read_reg(8'hA1, q);
            check(q, {7'h00, f[0]});
            for (int i = 0; i < 4; i++) begin
                @(posedge clk) {pin_en, dis_bit} <= i[1:0];
                settle();
                check({7'h00, lin3_en}, {7'h00, f[0] ? i[0] : i[1]});
            end
        end
    endtask : test_force_on
    task automatic test_reset();
        host.write_reg(8'hA2, 8'h5A);
        @(posedge clk) resetn <= 1'b0;
        #1;
        check({5'h00, shut, pg_out, lin3_en}, 8'h00);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        host.read_reg(8'hA2, q);
        check(q, 8'h00);
    endtask : test_reset
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        resetn = 1'b0;
        pin_en = 1'b0;
        dis_bit = 1'b1;
        flt1 = '0;
        flt2 = '0;
        pg1 = '0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        test_defaults();
        test_shutdown();
        test_pg_group();
        test_force_on();
        test_reset();
        give_verdict();
    end
endmodule : testbench
